// file: pkg/tcdma_pkg.sv
// package with constants and types of the transfer controller channel engine
// -----------------------------------------------------------------------------
// Overview of operation
// [R1] each transfer runs arbitration, fetch, source, destination, write-back in order
// [R2] simultaneous requests from several channels make arbitration take two cycles; the engine takes one cycle when streaming the next burst from write-back
// [R3] fetch reads configuration in one cycle, waits while the cpu holds it; the engine's fetch takes at least two cycles
// [R4] only one channel may be in the fetch phase at a time
// [R5] source and destination spokes used only when granted; stall otherwise
// [R6] source not ready holds the transfer until the source becomes ready
// [R7] destination not ready: keep filling the 16-byte fifo, drain when ready
// [R8] stop reading source while fifo is full, resume when space frees
// [R9] aligned 4-byte group reads in one cycle; offset start costs extra cycles; the engine reads one byte per cycle at any offset
// [R10] total data divided into equal-size bursts
// [R11] burst-request gate bit 7 of config word 0 needs fresh request per burst
// [R12] with gate set, full phase sequence repeats for every burst
// [R13] restore bit 5 clear: descriptor keeps final addresses and count
// [R14] restore bit set: work copy used, original restored after completion
// [R15] next-descriptor pointer in descriptor word 0 selects following descriptor
// [R16] a single descriptor with no chaining moves data once
// [R17] self-pointing descriptor repeats continuously
// [R18] two descriptors pointing at each other form ping-pong buffering
// [R19] ring of descriptors loops from last back to first
// [R20] a descriptor may write a later descriptor, which uses the new address
// [R21] each descriptor in a chain addresses a separate memory segment
// [R22] lower priority channel preempted only during its source engine phase; the engine also yields to a higher channel at write-back between bursts
// -----------------------------------------------------------------------------
package tcdma_pkg;
  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int CFG0_REQ_PER_BURST_BIT = 7;
  localparam int BASIC_CFG_RESTORE_BIT  = 5;
  // descriptor word 0: [31:24] next pointer, [23] end-of-chain, [15:0] count
  localparam int D0_NEXT_LSB   = 24;
  localparam int D0_NEXT_MSB   = 31;
  localparam int D0_END_BIT    = 23;
  localparam int D0_COUNT_MSB  = 15;
  localparam int CFG0_BURST_MSB = 6;  // burst size in bytes, bits [6:0]
  // ---------------------------------------------------------------------------
  // sizes and timing
  // ---------------------------------------------------------------------------
  localparam int FIFO_BYTES      = 16;
  localparam int WORD_BYTES      = 4;
  localparam int ARB_CYC_SINGLE  = 1;
  localparam int ARB_CYC_MULTI   = 2;
  localparam logic [1:0] BYTE_ZERO = 2'h0;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [7:0]  PTR_ZERO   = 8'h00;

  typedef enum logic [2:0] {
    TCDMA_IDLE  = 3'h0,
    TCDMA_ARB   = 3'h1,
    TCDMA_FETCH = 3'h2,
    TCDMA_SRC   = 3'h3,
    TCDMA_DRAIN = 3'h4,
    TCDMA_WB    = 3'h5
  } tcdma_state_t;
endpackage

// file: pkg/tcdma_fifo_if.sv
// interface joining the engine with its internal byte fifo
`timescale 1ns/100ps
interface tcdma_fifo_if;
  logic       push;
  logic [7:0] push_data;
  logic       pop;
  logic [7:0] pop_data;
  logic       full;
  logic       empty;
  logic [4:0] level;
  modport eng  (output push, push_data, pop, input pop_data, full, empty, level);
  modport fifo (input push, push_data, pop, output pop_data, full, empty, level);
endinterface

// file: rtl/tcdma_fifo.sv
// internal byte fifo of the hub, registered read data
`timescale 1ns/100ps
module tcdma_fifo #(
  parameter int DEPTH = tcdma_pkg::FIFO_BYTES
) (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // engine side
  tcdma_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0]    mem_ff [DEPTH];
  logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic [7:0]    rd_ff, nxt_rd;
  logic          do_push, do_pop;

  // next pointers and count; pop data read ahead into a register
  always_comb begin
    do_push = f.push && (cnt_ff != (AW+1)'(DEPTH));
    do_pop  = f.pop && (cnt_ff != '0);
    nxt_wp  = do_push ? wp_ff + 1'b1 : wp_ff;
    nxt_rp  = do_pop ? rp_ff + 1'b1 : rp_ff;
    nxt_cnt = cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
    nxt_rd  = mem_ff[nxt_rp];
    if (do_push && (nxt_cnt == (AW+1)'(1))) begin
      nxt_rd = f.push_data;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
      rd_ff  <= 8'h00;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
      rd_ff  <= nxt_rd;
    end
  end

  // storage, no reset needed
  always_ff @(posedge i_clock) begin
    if (do_push) begin
      mem_ff[wp_ff] <= f.push_data;
    end
  end

  assign f.pop_data = rd_ff;
  assign f.full     = (cnt_ff == (AW+1)'(DEPTH));
  assign f.empty    = (cnt_ff == '0);
  assign f.level    = 5'(cnt_ff);
endmodule

// file: rtl/tcdma_desc_mem.sv
// descriptor memory: word 0 and address words per descriptor, registered read
`timescale 1ns/100ps
module tcdma_desc_mem #(
  parameter int ENTRIES = 128
) (
  // clock
  input  wire logic        i_clock,
  // port a: cpu write
  input  wire logic        i_we_a,
  input  wire logic [7:0]  i_addr_a,
  input  wire logic [95:0] i_wdata_a,
  // port b: engine read and update
  input  wire logic        i_we_b,
  input  wire logic [7:0]  i_addr_b,
  input  wire logic [95:0] i_wdata_b,
  output logic      [95:0] o_rdata_b
);
  logic [95:0] mem_ff [ENTRIES];
  logic [95:0] rd_ff;

  // engine write wins over a cpu write to the same entry
  always_ff @(posedge i_clock) begin
    if (i_we_a && !(i_we_b && i_addr_b == i_addr_a)) begin
      mem_ff[i_addr_a[$clog2(ENTRIES)-1:0]] <= i_wdata_a;
    end
    if (i_we_b) begin
      mem_ff[i_addr_b[$clog2(ENTRIES)-1:0]] <= i_wdata_b;
    end
    rd_ff <= mem_ff[i_addr_b[$clog2(ENTRIES)-1:0]];
  end

  assign o_rdata_b = rd_ff;
endmodule

// file: rtl/tcdma_engine.sv
// transfer controller channel engine: phases, fifo staging and descriptor chaining
`timescale 1ns/100ps
module tcdma_engine #(
  parameter int CHANNELS = 8,
  parameter int ENTRIES  = 128
) (
  // clock and reset
  input  wire logic                 i_clock,
  input  wire logic                 i_rst,
  // channel requests and per-channel configuration
  input  wire logic [CHANNELS-1:0]  i_req,
  input  wire logic [CHANNELS-1:0]  i_cfg0_req_per_burst,   // channel_config_word0 bit 7
  input  wire logic [CHANNELS*7-1:0] i_cfg0_burst_bytes,
  input  wire logic [CHANNELS-1:0]  i_restore,              // basic config bit 5
  input  wire logic [CHANNELS*8-1:0] i_first_desc,
  // cpu access to the configuration space and descriptor memory
  input  wire logic                 i_cpu_cfg_busy,
  input  wire logic                 i_cpu_we,
  input  wire logic [7:0]           i_cpu_addr,
  input  wire logic [95:0]          i_cpu_wdata,
  // spoke arbitration
  input  wire logic                 i_src_grant,
  input  wire logic                 i_dst_grant,
  // source peripheral
  input  wire logic                 i_src_ready,
  input  wire logic [31:0]          i_src_rdata,
  // destination peripheral
  input  wire logic                 i_dst_ready,
  // spoke requests and data
  output logic                      o_src_rd,
  output logic [31:0]               o_src_addr,
  output logic                      o_dst_wr,
  output logic [31:0]               o_dst_addr,
  output logic [7:0]                o_dst_wdata,
  // status
  output logic                      o_busy,
  output logic [2:0]                o_phase,
  output logic [CHANNELS-1:0]       o_done
);
  localparam int CW = $clog2(CHANNELS);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  tcdma_pkg::tcdma_state_t st_ff, nxt_st;
  logic [1:0]     arb_cnt_ff, nxt_arb_cnt;
  logic [CW-1:0]  ch_ff, nxt_ch;
  logic [7:0]     desc_ff, nxt_desc;
  logic [95:0]    work_ff, nxt_work;     // live copy: word0, source, destination
  logic [95:0]    orig_ff, nxt_orig;     // fetched original descriptor
  logic [6:0]     burst_left_ff, nxt_burst_left;
  logic           fresh_ff, nxt_fresh;   // next fetch loads a new original
  logic           fetch_wait_ff, nxt_fetch_wait;
  logic           src_rd_ff, nxt_src_rd;
  logic [31:0]    src_addr_ff, nxt_src_addr;
  logic           dst_wr_ff, nxt_dst_wr;
  logic [31:0]    dst_addr_ff, nxt_dst_addr;
  logic [7:0]     dst_wdata_ff, nxt_dst_wdata;
  logic [CHANNELS-1:0] done_ff, nxt_done;
  logic           busy_ff, nxt_busy;

  // descriptor memory port b
  logic           mem_we;
  logic [7:0]     mem_addr;
  logic [95:0]    mem_wdata;
  logic [95:0]    mem_rdata;
  logic [CW-1:0]  win_ch;
  logic           any_req, multi_req;
  logic [15:0]    count;
  logic [7:0]     src_byte;

  tcdma_fifo_if ff_if ();

  tcdma_fifo #(.DEPTH(tcdma_pkg::FIFO_BYTES)) u_fifo (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .f       (ff_if)
  );

  tcdma_desc_mem #(.ENTRIES(ENTRIES)) u_desc (
    .i_clock   (i_clock),
    .i_we_a    (i_cpu_we),
    .i_addr_a  (i_cpu_addr),
    .i_wdata_a (i_cpu_wdata),
    .i_we_b    (mem_we),
    .i_addr_b  (mem_addr),
    .i_wdata_b (mem_wdata),
    .o_rdata_b (mem_rdata)
  );

  // ---------------------------------------------------------------------------
  // request pick: lowest channel number is highest priority
  // ---------------------------------------------------------------------------
  always_comb begin
    win_ch    = '0;
    any_req   = |i_req;
    multi_req = (i_req & (i_req - 1'b1)) != '0;  // [R2]
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (i_req[i]) begin
        win_ch = CW'(i);
      end
    end
  end

  assign count    = work_ff[tcdma_pkg::D0_COUNT_MSB:0];
  // byte lane picked from the current address offset
  assign src_byte = i_src_rdata[{src_addr_ff[1:0], 3'h0} +: 8];

  // ---------------------------------------------------------------------------
  // phase sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_st          = st_ff;
    nxt_arb_cnt     = arb_cnt_ff;
    nxt_ch          = ch_ff;
    nxt_desc        = desc_ff;
    nxt_work        = work_ff;
    nxt_orig        = orig_ff;
    nxt_burst_left  = burst_left_ff;
    nxt_fresh       = fresh_ff;
    nxt_fetch_wait  = fetch_wait_ff;
    nxt_src_rd      = 1'b0;
    nxt_src_addr    = src_addr_ff;
    nxt_dst_wr      = 1'b0;
    nxt_dst_addr    = dst_addr_ff;
    nxt_dst_wdata   = dst_wdata_ff;
    nxt_done        = '0;
    nxt_busy        = (st_ff != tcdma_pkg::TCDMA_IDLE);
    mem_we          = 1'b0;
    mem_addr        = desc_ff;
    mem_wdata       = work_ff;
    ff_if.push      = 1'b0;
    ff_if.push_data = src_byte;
    ff_if.pop       = 1'b0;
    unique case (st_ff)
      tcdma_pkg::TCDMA_IDLE: begin
        if (any_req) begin
          nxt_st      = tcdma_pkg::TCDMA_ARB;  // [R1]
          nxt_ch      = win_ch;
          // one live copy: another channel's open progress is dropped
          if (win_ch != ch_ff) begin
            nxt_work = '0;
          end
          nxt_arb_cnt = multi_req ? 2'(tcdma_pkg::ARB_CYC_MULTI) : 2'(tcdma_pkg::ARB_CYC_SINGLE);  // [R2]
        end
      end
      tcdma_pkg::TCDMA_ARB: begin
        nxt_arb_cnt = arb_cnt_ff - 1'b1;
        if (arb_cnt_ff == 2'(tcdma_pkg::ARB_CYC_SINGLE)) begin
          nxt_st         = tcdma_pkg::TCDMA_FETCH;  // [R1]
          nxt_fetch_wait = 1'b1;
          // resume an open chain, otherwise start at the channel's head
          if (work_ff[tcdma_pkg::D0_COUNT_MSB:0] == tcdma_pkg::COUNT_ZERO) begin
            nxt_desc  = i_first_desc[ch_ff*8 +: 8];
            nxt_fresh = 1'b1;
          end
        end
      end
      tcdma_pkg::TCDMA_FETCH: begin
        // single fetch slot shared by all channels; cpu holds it while busy
        mem_addr = desc_ff;
        if (i_cpu_cfg_busy) begin
          nxt_fetch_wait = 1'b1;  // [R3]
        end else if (fetch_wait_ff) begin
          nxt_fetch_wait = 1'b0;  // [R4] read issued, data next cycle
        end else begin
          if (fresh_ff) begin
            nxt_orig = mem_rdata;  // later bursts keep the first copy
          end
          nxt_fresh      = 1'b0;
          nxt_work       = mem_rdata;  // [R14]
          nxt_src_addr   = mem_rdata[63:32];
          nxt_dst_addr   = mem_rdata[95:64];
          nxt_burst_left = i_cfg0_burst_bytes[ch_ff*7 +: 7];  // [R10]
          nxt_st         = tcdma_pkg::TCDMA_SRC;
        end
      end
      tcdma_pkg::TCDMA_SRC: begin
        // preemption point mid-burst: a higher channel may take over here, or at write-back between bursts
        if (any_req && win_ch < ch_ff) begin
          nxt_st   = tcdma_pkg::TCDMA_WB;  // [R22]
          nxt_busy = 1'b1;
        end else if (count == tcdma_pkg::COUNT_ZERO || burst_left_ff == '0) begin
          nxt_st = tcdma_pkg::TCDMA_DRAIN;
        end else if (i_src_grant && i_src_ready && !ff_if.full) begin  // [R5] [R6] [R8]
          ff_if.push     = 1'b1;  // [R7]
          nxt_src_rd     = 1'b1;
          nxt_src_addr   = src_addr_ff + 32'h0000_0001;  // [R9]
          nxt_work[tcdma_pkg::D0_COUNT_MSB:0] = count - 16'h0001;
          nxt_work[63:32] = src_addr_ff + 32'h0000_0001;
          nxt_burst_left = burst_left_ff - 7'h01;
        end
        // drain to the destination in parallel whenever it accepts
        if (i_dst_grant && i_dst_ready && !ff_if.empty) begin  // [R5] [R7]
          ff_if.pop     = 1'b1;
          nxt_dst_wr    = 1'b1;
          nxt_dst_wdata = ff_if.pop_data;
          nxt_dst_addr  = dst_addr_ff + 32'h0000_0001;
          nxt_work[95:64] = dst_addr_ff + 32'h0000_0001;
        end
      end
      tcdma_pkg::TCDMA_DRAIN: begin
        if (ff_if.empty) begin
          nxt_st = tcdma_pkg::TCDMA_WB;  // [R1]
        end else if (i_dst_grant && i_dst_ready) begin  // [R5] [R7]
          ff_if.pop     = 1'b1;
          nxt_dst_wr    = 1'b1;
          nxt_dst_wdata = ff_if.pop_data;
          nxt_dst_addr  = dst_addr_ff + 32'h0000_0001;
          nxt_work[95:64] = dst_addr_ff + 32'h0000_0001;
        end
      end
      tcdma_pkg::TCDMA_WB: begin
        nxt_st = tcdma_pkg::TCDMA_IDLE;
        mem_we = 1'b1;
        // restore bit selects original or final values on completion
        mem_wdata = (count == tcdma_pkg::COUNT_ZERO && i_restore[ch_ff]) ? orig_ff : work_ff;  // [R13] [R14]
        if (count == tcdma_pkg::COUNT_ZERO) begin
          // follow the next pointer: self, partner or ring head all work alike
          nxt_desc = work_ff[tcdma_pkg::D0_NEXT_MSB:tcdma_pkg::D0_NEXT_LSB];  // [R15] [R17] [R18] [R19] [R21]
          if (work_ff[tcdma_pkg::D0_END_BIT]) begin
            nxt_done[ch_ff] = 1'b1;  // [R16]
            nxt_work        = '0;
          end else begin
            // reload so a descriptor rewritten by an earlier one is seen
            nxt_work[tcdma_pkg::D0_COUNT_MSB:0] = 16'h0001;  // [R20]
            nxt_fresh = 1'b1;
          end
        end else if (!i_cfg0_req_per_burst[ch_ff] && !(any_req && win_ch < ch_ff)) begin
          nxt_st   = tcdma_pkg::TCDMA_ARB;  // stream next burst without a fresh request
          nxt_arb_cnt = 2'(tcdma_pkg::ARB_CYC_SINGLE);
        end
        // with the gate set, the channel waits in idle for a new request  [R11] [R12]
      end
      default: begin
        nxt_st = tcdma_pkg::TCDMA_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_ff         <= tcdma_pkg::TCDMA_IDLE;
      arb_cnt_ff    <= 2'h0;
      ch_ff         <= '0;
      desc_ff       <= tcdma_pkg::PTR_ZERO;
      work_ff       <= '0;
      orig_ff       <= '0;
      burst_left_ff <= 7'h00;
      fresh_ff      <= 1'b0;
      fetch_wait_ff <= 1'b0;
      src_rd_ff     <= 1'b0;
      src_addr_ff   <= 32'h0000_0000;
      dst_wr_ff     <= 1'b0;
      dst_addr_ff   <= 32'h0000_0000;
      dst_wdata_ff  <= 8'h00;
      done_ff       <= '0;
      busy_ff       <= 1'b0;
    end else begin
      st_ff         <= nxt_st;
      arb_cnt_ff    <= nxt_arb_cnt;
      ch_ff         <= nxt_ch;
      desc_ff       <= nxt_desc;
      work_ff       <= nxt_work;
      orig_ff       <= nxt_orig;
      burst_left_ff <= nxt_burst_left;
      fresh_ff      <= nxt_fresh;
      fetch_wait_ff <= nxt_fetch_wait;
      src_rd_ff     <= nxt_src_rd;
      src_addr_ff   <= nxt_src_addr;
      dst_wr_ff     <= nxt_dst_wr;
      dst_addr_ff   <= nxt_dst_addr;
      dst_wdata_ff  <= nxt_dst_wdata;
      done_ff       <= nxt_done;
      busy_ff       <= nxt_busy;
    end
  end

  // outputs straight from flip-flops
  assign o_src_rd    = src_rd_ff;
  assign o_src_addr  = src_addr_ff;
  assign o_dst_wr    = dst_wr_ff;
  assign o_dst_addr  = dst_addr_ff;
  assign o_dst_wdata = dst_wdata_ff;
  assign o_busy      = busy_ff;
  assign o_phase     = st_ff;
  assign o_done      = done_ff;
endmodule

// file: bench/tcdma_spoke_model.sv
// far-side model: source and destination spokes, peripheral readiness and cpu hold of config space
`timescale 1ns/100ps
module tcdma_spoke_model (
  // stall controls from the bench
  input  wire logic        i_stall_en,
  input  wire logic        i_dst_block,
  input  wire logic [7:0]  i_rnd,
  // source address from the engine
  input  wire logic [31:0] i_src_addr,
  // spoke answers
  output logic             o_src_grant,
  output logic             o_src_ready,
  output logic             o_dst_grant,
  output logic             o_dst_ready,
  output logic             o_cpu_cfg_busy,
  output logic [31:0]      o_src_rdata
);
  logic [31:0] word;
  // addressed word; inverted unless granted and ready
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      word[8*k +: 8] = {i_src_addr[7:2], k[1:0]} ^ i_src_addr[15:8] ^ 8'h5A;
    end
    o_src_grant    = !i_stall_en | i_rnd[0];
    o_src_ready    = !i_stall_en | i_rnd[1];
    o_dst_grant    = !i_stall_en | i_rnd[2];
    o_dst_ready    = !i_dst_block & (!i_stall_en | i_rnd[3]);
    o_cpu_cfg_busy = i_stall_en & i_rnd[4] & i_rnd[5];
    o_src_rdata    = (o_src_grant & o_src_ready) ? word : ~word;
  end
endmodule

// file: bench/tcdma_engine_props.sv
// checker of the engine's phase, spoke and fifo behaviour at its ports
`timescale 1ns/100ps
module tcdma_engine_props #(
  parameter int CHANNELS = 8,
  parameter int ENTRIES  = 128
) (
  // clock, reset and requests
  input wire logic                  i_clock,
  input wire logic                  i_rst,
  input wire logic [CHANNELS-1:0]   i_req,
  input wire logic                  i_cpu_cfg_busy,
  // spoke handshakes
  input wire logic                  i_src_grant,
  input wire logic                  i_src_ready,
  input wire logic                  i_dst_grant,
  input wire logic                  i_dst_ready,
  // engine outputs
  input wire logic                  o_src_rd,
  input wire logic [31:0]           o_src_addr,
  input wire logic                  o_dst_wr,
  input wire logic [2:0]            o_phase,
  input wire logic [CHANNELS-1:0]   o_done
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic [5:0] occ_ff;
  logic [5:0] nxt_occ;
  // bytes taken from the source and not yet written out
  always_comb begin
    nxt_occ = (o_phase == 3'h0) ? 6'h00 : occ_ff + 6'(o_src_rd) - 6'(o_dst_wr);
  end
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      occ_ff <= 6'h00;
    end else begin
      occ_ff <= nxt_occ;
    end
  end
  a_arb_multi_two: assert property (($past(o_phase) == 3'h0 && o_phase == 3'h1 && $past($countones(i_req)) > 1)
    |=> o_phase == 3'h1) else $error("short contested arbitration");
  a_arb_single_one: assert property (($past(o_phase) == 3'h0 && o_phase == 3'h1 && $past($countones(i_req)) == 1)
    |=> o_phase == 3'h2) else $error("long single arbitration");
  a_arb_no_third: assert property (o_phase == 3'h1 [*2] |=> o_phase != 3'h1)
    else $error("arbitration longer than two cycles");
  a_fetch_from_arb: assert property ($changed(o_phase) && o_phase == 3'h2 |-> $past(o_phase) == 3'h1)
    else $error("fetch not after arbitration");
  a_wb_after_engine: assert property ($changed(o_phase) && o_phase == 3'h5 |-> $past(o_phase) inside {3'h3, 3'h4})
    else $error("write-back entered before the engine phases");
  a_fetch_cpu_hold: assert property (o_phase == 3'h2 && i_cpu_cfg_busy |=> o_phase == 3'h2)
    else $error("fetch left while the cpu held the configuration");
  a_fetch_min_two: assert property ($rose(o_phase == 3'h2) |=> o_phase == 3'h2)
    else $error("fetch shorter than two cycles");
  a_src_needs_grant: assert property (o_src_rd |-> $past(i_src_grant && i_src_ready))
    else $error("source read unqualified");
  a_dst_needs_grant: assert property (o_dst_wr |-> $past(i_dst_grant && i_dst_ready))
    else $error("destination write unqualified");
  a_src_addr_step: assert property (o_src_rd |-> o_src_addr == $past(o_src_addr) + 32'h1)
    else $error("source address did not advance by one byte");
  a_fifo_bound: assert property (occ_ff <= 6'h10)
    else $error("more than sixteen bytes staged");
  a_done_after_wb: assert property (|o_done |-> $past(o_phase) == 3'h5)
    else $error("done pulse not after write-back");
  c_multi_req: cover property ($past(o_phase) == 3'h0 && o_phase == 3'h1 && $past($countones(i_req)) > 1);
  c_fifo_full: cover property (occ_ff == 6'h10);
  c_cpu_hold: cover property (o_phase == 3'h2 && i_cpu_cfg_busy);
  c_done: cover property (|o_done);
endmodule

bind tcdma_engine tcdma_engine_props #(.CHANNELS(CHANNELS), .ENTRIES(ENTRIES)) props_u (.*);

// file: bench/tcdma_engine_tb.sv
// self-checking bench of the transfer controller channel engine
`timescale 1ns/100ps
module tcdma_engine_tb;
  logic        i_clock, i_rst, i_cpu_cfg_busy, i_cpu_we, i_src_grant, i_dst_grant, i_src_ready, i_dst_ready;
  logic        o_src_rd, o_dst_wr, o_busy, stall_en, dst_block;
  logic [1:0]  i_req, i_cfg0_req_per_burst, i_restore, o_done;
  logic [13:0] i_cfg0_burst_bytes;
  logic [15:0] i_first_desc;
  logic [7:0]  i_cpu_addr, o_dst_wdata, rnd_ctl;
  logic [95:0] i_cpu_wdata;
  logic [31:0] i_src_rdata, o_src_addr, o_dst_addr, seed;
  logic [2:0]  o_phase, prev_ph;
  logic [7:0]  exp_q[$];
  int          n_mismatch = 0, n_checks = 0, n_wr, n_src, n_done, n_arb;

  tcdma_engine #(.CHANNELS(2), .ENTRIES(128)) dut_u (.*);
  tcdma_spoke_model model_u (
    .i_stall_en(stall_en), .i_dst_block(dst_block), .i_rnd(rnd_ctl), .i_src_addr(o_src_addr),
    .o_src_grant(i_src_grant), .o_src_ready(i_src_ready), .o_dst_grant(i_dst_grant), .o_dst_ready(i_dst_ready),
    .o_cpu_cfg_busy(i_cpu_cfg_busy), .o_src_rdata(i_src_rdata));

  // xorshift source of the random stalls
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // value the source holds at a byte address
  function automatic logic [7:0] dbyte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic clr();
    n_wr = 0;
    n_src = 0;
    n_done = 0;
    n_arb = 0;
  endtask
  task automatic seg(input logic [31:0] src, input int cnt);
    for (int i = 0; i < cnt; i++) exp_q.push_back(dbyte(src + 32'(i)));
  endtask
  // cpu write of one descriptor; destination sits a fixed distance above the source
  task automatic wdesc(input logic [7:0] idx, input logic [7:0] nxt, input logic fin, input logic [31:0] src,
                       input logic [15:0] n = 16'h0008);
    @(negedge i_clock);
    i_cpu_we = 1'b1;
    i_cpu_addr = idx;
    i_cpu_wdata = {src + 32'h1000_0000, src, nxt, fin, 7'h00, n};
    @(negedge i_clock);
    i_cpu_we = 1'b0;
  endtask
  // request channels, release each on its done pulse, wait for the expected bytes
  task automatic go(input logic [1:0] mask, input int tgt);
    @(negedge i_clock);
    i_req = mask;
    for (int c = 0; c < 5000 && (exp_q.size() > 0 || (i_req != 2'b00 && tgt >= 0)); c++) begin
      @(negedge i_clock);
      i_req = i_req & ~o_done;
    end
    repeat (40) @(negedge i_clock);
    if (tgt >= 0) chk(n_wr, tgt);
  endtask
  task automatic rst_pulse();
    @(negedge i_clock);
    i_req = 2'b00;
    i_rst = 1'b1;
    repeat (3) @(negedge i_clock);
    i_rst = 1'b0;
    clr();
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // clock
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // random stalls, output monitor and byte comparison
  always @(negedge i_clock) begin
    seed = xs(seed);
    rnd_ctl <= seed[7:0];
    if (o_dst_wr === 1'b1) begin
      n_wr++;
      if (exp_q.size() > 0) chk(o_dst_wdata, exp_q.pop_front());
    end
    if (o_src_rd === 1'b1) n_src++;
    if (o_done !== 2'b00) n_done += $countones(o_done);
    if (o_phase === 3'h1 && prev_ph !== 3'h1) n_arb++;
    prev_ph = o_phase;
  end
  // watchdog
  initial begin
    #900000;
    n_mismatch++;
    conclude();
  end
  // main sequence
  initial begin
    seed = 32'h81AE15E6;
    {stall_en, dst_block, i_cpu_we, i_rst} = 4'h1;
    {i_req, i_cfg0_req_per_burst, i_cpu_addr} = '0;
    i_restore = 2'b11;
    i_cfg0_burst_bytes = {7'h04, 7'h08};
    i_first_desc = 16'h0000;
    i_cpu_wdata = '0;
    clr();
    repeat (12) @(negedge i_clock);
    i_rst = 1'b0;
    // single descriptor run twice, restored in between
    wdesc(8'h00, 8'h00, 1'b1, 32'h0000_0040);
    seg(32'h40, 8);
    seg(32'h40, 8);
    go(2'b01, 8);
    go(2'b01, 16);
    chk(n_done, 2);
    // misaligned source under random stalls and cpu holds
    stall_en = 1'b1;
    clr();
    wdesc(8'h01, 8'h00, 1'b1, 32'h0000_0101);
    i_first_desc[7:0] = 8'h01;
    seg(32'h101, 8);
    go(2'b01, 8);
    // gather chain of separate segments
    clr();
    wdesc(8'h02, 8'h03, 1'b0, 32'h0000_0203);
    wdesc(8'h03, 8'h04, 1'b0, 32'h0000_0350);
    wdesc(8'h04, 8'h00, 1'b1, 32'h0000_04A1);
    i_first_desc[7:0] = 8'h02;
    seg(32'h203, 8);
    seg(32'h350, 8);
    seg(32'h4A1, 8);
    go(2'b01, 24);
    chk(n_done, 1);
    // destination blocked: fifo fills to sixteen bytes and stops
    clr();
    i_cfg0_burst_bytes[6:0] = 7'h18;
    dst_block = 1'b1;
    wdesc(8'h05, 8'h00, 1'b1, 32'h0000_0600, 16'h0018);
    i_first_desc[7:0] = 8'h05;
    seg(32'h600, 24);
    i_req = 2'b01;
    repeat (150) @(negedge i_clock);
    chk(n_wr, 0);
    chk(n_src, 16);
    dst_block = 1'b0;
    go(2'b01, 24);
    chk(n_src, 24);
    // burst-request gate: each burst of four needs its own request
    clr();
    i_cfg0_req_per_burst = 2'b10;
    i_first_desc[15:8] = 8'h08;
    wdesc(8'h08, 8'h00, 1'b1, 32'h0000_0700);
    seg(32'h700, 8);
    @(negedge i_clock);
    i_req = 2'b10;
    @(negedge i_clock);
    i_req = 2'b00;
    repeat (150) @(negedge i_clock);
    chk(n_wr, 4);
    for (int c = 0; c < 3000 && exp_q.size() > 0; c++) begin
      @(negedge i_clock);
      i_req = (o_phase === 3'h0) ? 2'b10 : 2'b00;
    end
    i_req = 2'b00;
    repeat (40) @(negedge i_clock);
    chk(n_wr, 8);
    chk(n_arb, 2);
    // two channels at once: higher priority channel first
    clr();
    i_cfg0_req_per_burst = 2'b00;
    wdesc(8'h09, 8'h00, 1'b1, 32'h0000_0800);
    i_first_desc = 16'h0908;
    seg(32'h700, 8);
    seg(32'h800, 8);
    go(2'b11, 16);
    chk(n_done, 2);
    // self-chained, ping-pong and ring descriptors, stopped by reset
    wdesc(8'h0A, 8'h0A, 1'b0, 32'h0000_0A00);
    wdesc(8'h0B, 8'h0C, 1'b0, 32'h0000_0B00);
    wdesc(8'h0C, 8'h0B, 1'b0, 32'h0000_0C05);
    wdesc(8'h0D, 8'h0E, 1'b0, 32'h0000_0D00);
    wdesc(8'h0E, 8'h0F, 1'b0, 32'h0000_0D40);
    wdesc(8'h0F, 8'h0D, 1'b0, 32'h0000_0E00);
    for (int m = 0; m < 3; m++) begin
      i_first_desc[7:0] = 8'h0A + 8'(m) + 8'(m > 1);
      for (int r = 0; r < 4; r++) seg(m == 0 ? 32'hA00 : m == 1 ? (r[0] ? 32'hC05 : 32'hB00) :
                                      r == 1 ? 32'hD40 : r == 2 ? 32'hE00 : 32'hD00, 8);
      go(2'b01, -1);
      chk(exp_q.size(), 0);
      rst_pulse();
    end
    conclude();
  end
endmodule
